// File: logic/thsv_supervisor.sv
// Thermal supervisor: status, events, masks, interrupt, converter shutdown and core reset
`timescale 1ns/10ps
`default_nettype none
module thsv_supervisor
    import thsv_pkg::*;
#(
    parameter int NUM_CONV = 2     // Converters under control
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Comparator indications from the sensor, asynchronous
    input  wire logic       temp_warn_cmp,
    input  wire logic       thermal_critical_status_cmp,
    input  wire logic       temp_por_cmp,
    // Converter control pins, asynchronous
    input  wire logic [1:0] control_input_pin,
    // Register access port from the interface block
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Device outputs
    output logic            interrupt_out_low,
    output logic            first_converter_on,
    output logic            second_converter_on,
    output logic            core_por
);

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (NUM_CONV != 2) begin : g_bad_conv
        $error("thsv_supervisor supports exactly two converters");
    end

    // ****************************************
    // Address decode
    // ****************************************
    // Shared by the write and read paths
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
        addr_hit = (a == target);
    endfunction

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NSYNC = 3 + NUM_CONV;
    logic [NSYNC-1:0] sync1_ff;    // First stage, read only by the second
    logic [NSYNC-1:0] sync2_ff;    // Second stage, safe to use
    logic [NSYNC-1:0] nxt_sync1;
    logic [NSYNC-1:0] nxt_sync2;

    // Gather asynchronous inputs into the chain
    always_comb begin
        nxt_sync1 = {control_input_pin, temp_por_cmp, thermal_critical_status_cmp, temp_warn_cmp};
        nxt_sync2 = sync1_ff;
    end

    // Two flops per input before any logic looks at it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    logic                warn_live;    // Warning level, synchronised
    logic                crit_live;    // Critical level, synchronised
    logic                por_live;     // Reset level, synchronised
    logic [NUM_CONV-1:0] pin_live;     // Control pins, synchronised
    assign warn_live = sync2_ff[0];
    assign crit_live = sync2_ff[1];
    assign por_live  = sync2_ff[2];
    assign pin_live  = sync2_ff[3 +: NUM_CONV];

    // ****************************************
    // Register writes
    // ****************************************
    logic       wr_events;             // Write to event register
    logic       wr_masks;              // Write to mask register
    logic [1:0] wr_conv;               // Write to each converter register
    assign wr_events  = reg_wr & addr_hit(reg_addr, EVENTS_ADDR);
    assign wr_masks   = reg_wr & addr_hit(reg_addr, MASKS_ADDR);
    assign wr_conv[0] = reg_wr & addr_hit(reg_addr, CONV_FIRST_ADDR);
    assign wr_conv[1] = reg_wr & addr_hit(reg_addr, CONV_SECOND_ADDR);

    // ****************************************
    // Latched events
    // ****************************************
    logic warn_event;                  // Latched warning event
    logic crit_event;                  // Latched critical event

    // Warning event cell
    thsv_event_cell u_warn_cell (
        .clk      (clk),
        .rstn     (rstn),
        .hold     (por_live),
        .cond     (warn_live),
        .clr      (wr_events & reg_wdata[WARN_BIT]),
        .event_ff (warn_event)
    );

    // Critical event cell
    thsv_event_cell u_crit_cell (
        .clk      (clk),
        .rstn     (rstn),
        .hold     (por_live),
        .cond     (crit_live),
        .clr      (wr_events & reg_wdata[CRIT_BIT]),
        .event_ff (crit_event)
    );

    // ****************************************
    // Masks, converter control, live flags
    // ****************************************
    logic [7:0]          masks_ff;     // Event mask register
    logic [7:0]          conv_ff [2];  // Converter control registers
    logic [7:0]          flags_ff;     // Live condition flags
    logic [NUM_CONV-1:0] pin_prev_ff;  // Pin level one cycle ago
    logic [7:0]          nxt_masks;
    logic [7:0]          nxt_conv [2];
    logic [7:0]          nxt_flags;
    logic [NUM_CONV-1:0] nxt_pin_prev;

    // Next values of the control state
    always_comb begin
        nxt_masks    = masks_ff;
        nxt_pin_prev = pin_live;
        nxt_flags    = ZERO_BYTE;
        nxt_flags[WARN_BIT] = warn_live;
        nxt_flags[CRIT_BIT] = crit_live;
        if (wr_masks) begin
            nxt_masks = reg_wdata & MASKS_WMSK;
        end
        for (int i = 0; i < NUM_CONV; i++) begin
            nxt_conv[i] = conv_ff[i];
            if (wr_conv[i]) begin
                // A direct enable write is one way back after shutdown
                nxt_conv[i] = reg_wdata & CONV_WMSK;
            end
            if (conv_ff[i][PIN_SEL_BIT] && (pin_live[i] != pin_prev_ff[i])) begin
                // Only a pin edge moves the enable; a level left high does nothing
                nxt_conv[i][EN_BIT] = pin_live[i];
            end
            if (crit_live) begin
                // Critical overrides the enable bit of every write and pin edge
                nxt_conv[i][EN_BIT] = 1'b0;
            end
        end
        if (por_live) begin
            // Core held in power-on reset while the die is that hot
            nxt_masks    = MASKS_RST;
            nxt_flags    = ZERO_BYTE;
            nxt_pin_prev = '0;
            for (int i = 0; i < NUM_CONV; i++) begin
                nxt_conv[i] = CONV_RST;
            end
        end
    end

    // Register stage of the control state
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            masks_ff    <= MASKS_RST;
            flags_ff    <= ZERO_BYTE;
            pin_prev_ff <= '0;
            for (int i = 0; i < NUM_CONV; i++) begin
                conv_ff[i] <= CONV_RST;
            end
        end else begin
            masks_ff    <= nxt_masks;
            flags_ff    <= nxt_flags;
            pin_prev_ff <= nxt_pin_prev;
            for (int i = 0; i < NUM_CONV; i++) begin
                conv_ff[i] <= nxt_conv[i];
            end
        end
    end

    // ****************************************
    // Read data, interrupt and core reset
    // ****************************************
    logic [7:0] rdata_ff;              // Registered read data
    logic       irq_low_ff;            // Interrupt, active low
    logic       por_ff;                // Core reset output
    logic [7:0] nxt_rdata;
    logic [7:0] events_now;
    logic       nxt_irq_low;

    // Read mux, interrupt combine
    always_comb begin
        events_now           = ZERO_BYTE;
        events_now[WARN_BIT] = warn_event;
        events_now[CRIT_BIT] = crit_event;
        // Asserted low while any unmasked event is latched
        nxt_irq_low = ~|(events_now & ~masks_ff);
        nxt_rdata   = rdata_ff;
        if (reg_rd) begin
            // Unmapped addresses read as zero
            nxt_rdata = ZERO_BYTE;
            if (addr_hit(reg_addr, LIVE_FLAGS_ADDR)) begin
                nxt_rdata = flags_ff;
            end else if (addr_hit(reg_addr, EVENTS_ADDR)) begin
                nxt_rdata = events_now;
            end else if (addr_hit(reg_addr, MASKS_ADDR)) begin
                nxt_rdata = masks_ff;
            end else if (addr_hit(reg_addr, CONV_FIRST_ADDR)) begin
                nxt_rdata = conv_ff[0];
            end else if (addr_hit(reg_addr, CONV_SECOND_ADDR)) begin
                nxt_rdata = conv_ff[1];
            end
        end
    end

    // Output registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff   <= ZERO_BYTE;
            irq_low_ff <= 1'b1;
            por_ff     <= 1'b0;
        end else begin
            rdata_ff   <= nxt_rdata;
            irq_low_ff <= nxt_irq_low;
            por_ff     <= por_live;
        end
    end

    assign reg_rdata           = rdata_ff;
    assign interrupt_out_low   = irq_low_ff;
    assign first_converter_on  = conv_ff[0][EN_BIT];
    assign second_converter_on = conv_ff[1][EN_BIT];
    assign core_por            = por_ff;

endmodule // thsv_supervisor
`default_nettype wire

// File: logic/thsv_pkg.sv
// Package of register offsets, field positions and reset values for the thermal supervisor
//
// What this block does
// - Watch warning, critical and reset comparator thresholds
// - Warning sets live status and latches event
// - Unmasked warning event pulls interrupt low
// - Warning status follows live comparator level
// - Critical disables converters, sets status, latches event
// - Unmasked critical event pulls interrupt low
// - Converters stay disabled while critical persists
// - No automatic re-enable after critical clears
// - Reset threshold holds core in power-on reset
// - Writing ones clears exactly those event bits
// - Event arriving during clear is never lost
`default_nettype none
package thsv_pkg;

    // ****************************************
    // Nominal thresholds, degrees Celsius
    // ****************************************
    localparam int WARN_TEMP_C = 125;
    localparam int CRIT_TEMP_C = 140;
    localparam int POR_TEMP_C  = 150;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] LIVE_FLAGS_ADDR  = 8'h51;
    localparam logic [7:0] EVENTS_ADDR      = 8'h53;
    localparam logic [7:0] MASKS_ADDR       = 8'h55;
    localparam logic [7:0] CONV_FIRST_ADDR  = 8'h5D;
    localparam logic [7:0] CONV_SECOND_ADDR = 8'h5E;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int WARN_BIT    = 2;    // Warning in flags, events and masks
    localparam int CRIT_BIT    = 3;    // Critical in flags, events and masks
    localparam int EN_BIT      = 0;    // Converter enable
    localparam int PIN_SEL_BIT = 1;    // Converter follows its control pin

    // ****************************************
    // Reset values and write masks
    // ****************************************
    localparam logic [7:0] MASKS_RST  = 8'h00;
    localparam logic [7:0] CONV_RST   = 8'h00;
    localparam logic [7:0] MASKS_WMSK = 8'h0C;
    localparam logic [7:0] CONV_WMSK  = 8'h03;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;

    // ****************************************
    // Synchroniser depth
    // ****************************************
    localparam int SYNC_STAGES = 2;

endpackage
`default_nettype wire

// File: logic/thsv_event_cell.sv
// One latched event bit with rising-edge detection and write-one clear
`timescale 1ns/10ps
`default_nettype none
module thsv_event_cell (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Control
    input  wire logic hold,        // Core held in reset by overheating
    input  wire logic cond,        // Synchronised live condition
    input  wire logic clr,         // Write-one clear strobe for this bit
    // Result
    output var  logic event_ff     // Latched event
);
    logic cond_prev_ff;            // Condition one cycle ago
    logic nxt_event;
    logic nxt_cond_prev;

    // Next event: set on rising edge, set beats a same-cycle clear
    always_comb begin
        nxt_cond_prev = cond;
        nxt_event     = (event_ff & ~clr) | (cond & ~cond_prev_ff);
        if (hold) begin
            // Held reset also forgets the old level, so a hot die re-raises the event
            nxt_event     = 1'b0;
            nxt_cond_prev = 1'b0;
        end
    end

    // Register stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            event_ff     <= 1'b0;
            cond_prev_ff <= 1'b0;
        end else begin
            event_ff     <= nxt_event;
            cond_prev_ff <= nxt_cond_prev;
        end
    end

endmodule // thsv_event_cell
`default_nettype wire

// File: bench/thsv_supervisor_monitor.sv
// Port checker of the thermal supervisor
`timescale 1ns/10ps
`default_nettype none
module thsv_supervisor_monitor
    import thsv_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Inputs watched
    input wire logic       temp_warn_cmp,
    input wire logic       thermal_critical_status_cmp,
    input wire logic       temp_por_cmp,
    input wire logic [1:0] control_input_pin,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    // Outputs watched
    input wire logic [7:0] reg_rdata,
    input wire logic       interrupt_out_low,
    input wire logic       first_converter_on,
    input wire logic       second_converter_on,
    input wire logic       core_por
);
    // ****
    // Properties, all on the one clock
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Four samples cover the two sync flops plus the register
    AST_CRIT_OFF: assert property (
        thermal_critical_status_cmp[*4] |-> !first_converter_on && !second_converter_on)
        else $error("converter on during critical");
    AST_CONV_CAUSE: assert property (
        $rose(first_converter_on) |-> ($past(reg_wr) && $past(reg_addr) == CONV_FIRST_ADDR)
        || $past(control_input_pin[0], 3))
        else $error("converter came on by itself");
    AST_POR_ON: assert property (
        temp_por_cmp[*4] |-> core_por)
        else $error("core reset missing");
    AST_POR_OFF: assert property (
        (!temp_por_cmp)[*4] |-> !core_por)
        else $error("core reset without cause");
    AST_IRQ_POR: assert property (
        core_por[*3] |-> interrupt_out_low)
        else $error("interrupt during core reset");
    AST_IRQ_CAUSE: assert property (
        $fell(interrupt_out_low) |-> $past(temp_warn_cmp, 4) || $past(thermal_critical_status_cmp, 4)
        || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("interrupt without event");
    // Read data only moves on a read, outside the internal reset
    AST_RDATA_HOLD: assert property (
        (!temp_por_cmp)[*4] ##0 !reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    AST_UNMAPPED: assert property (
        reg_rd && reg_addr == 8'h00 |=> reg_rdata == ZERO_BYTE)
        else $error("unmapped read not zero");
endmodule // thsv_supervisor_monitor
`default_nettype wire

// File: bench/thsv_host_model.sv
// Host model driving the register port of the supervisor
`timescale 1ns/10ps
`default_nettype none
module thsv_host_model (
    // Clock and answer
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    // Requests
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write strobe; data inverted after so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge clk);
        #1 {reg_wdata, reg_wr} = {~d, 1'b0};
    endtask
    // Read data is registered at the strobe's edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge clk);
        #1 reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    // Clear events by writing back what was read
    task automatic clr_events(output logic [7:0] v);
        rd(8'h53, v);
        wr(8'h53, v);
    endtask
endmodule // thsv_host_model
`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench of the thermal supervisor
`timescale 1ns/10ps
`default_nettype none
module tb;
    import thsv_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} thsv_row_type;
    logic       clk, rstn, temp_warn_cmp, thermal_critical_status_cmp, temp_por_cmp, reg_wr, reg_rd;
    logic       interrupt_out_low, first_converter_on, second_converter_on, core_por;
    logic [1:0] control_input_pin;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    int         fail_count = 0;
    int         compares = 0;
    // Rows: address, value written, value read back
    thsv_row_type rows [7] = '{'{8'h55, 8'hFF, 8'h0C}, '{8'h5D, 8'h02, 8'h02},
        '{8'h5E, 8'hFF, 8'h03}, '{8'h51, 8'hFF, 8'h00}, '{8'h53, 8'hFF, 8'h00},
        '{8'h00, 8'hFF, 8'h00}, '{8'h7F, 8'h01, 8'h00}};
    thsv_supervisor u_thsv_supervisor (.clk, .rstn, .temp_warn_cmp, .thermal_critical_status_cmp,
        .temp_por_cmp, .control_input_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .interrupt_out_low, .first_converter_on, .second_converter_on, .core_por);
    thsv_host_model u_thsv_host_model (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input string n, input logic [7:0] a, input logic [7:0] e);
        u_thsv_host_model.rd(a, v);
        chk(n, e, v);
    endtask
    // Bounded wait on one output; running out ends the run
    task automatic wt(input string n, input int s, input logic l);
        logic x;
        for (int i = 0; i < 20; i++) begin
            cyc(1);
            x = (s == 0) ? interrupt_out_low : (s == 1) ? first_converter_on : core_por;
            if (x === l) break;
        end
        chk(n, {7'h00, l}, {7'h00, x});
        if (x !== l) test_done();
    endtask
    task automatic test_done;
        $display("Compares %0d, errors %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        {rstn, temp_warn_cmp, thermal_critical_status_cmp, temp_por_cmp} = 4'h0;
        control_input_pin = 2'h0;
        cyc(10);
        rstn = 1'b1;
        chk("irq", 8'h01, {7'h00, interrupt_out_low});
        rdchk("masks", MASKS_ADDR, MASKS_RST);
        foreach (rows[k]) begin
            u_thsv_host_model.wr(rows[k].a, rows[k].d);
            rdchk("row", rows[k].a, rows[k].e);
        end
        u_thsv_host_model.wr(MASKS_ADDR, 8'h00);
        // Warning raises status, event and interrupt; clear while still hot
        temp_warn_cmp = 1'b1;
        wt("irq", 0, 1'b0);
        rdchk("flags", LIVE_FLAGS_ADDR, 8'h04);
        u_thsv_host_model.clr_events(v);
        chk("events", 8'h04, v);
        wt("irq", 0, 1'b1);
        cyc(10);
        rdchk("events", EVENTS_ADDR, 8'h00);
        temp_warn_cmp = 1'b0;
        cyc(5);
        rdchk("flags", LIVE_FLAGS_ADDR, 8'h00);
        // Masked warning stays quiet until unmasked
        u_thsv_host_model.wr(MASKS_ADDR, 8'h04);
        temp_warn_cmp = 1'b1;
        cyc(8);
        chk("irq", 8'h01, {7'h00, interrupt_out_low});
        u_thsv_host_model.wr(MASKS_ADDR, 8'h00);
        wt("irq", 0, 1'b0);
        temp_warn_cmp = 1'b0;
        u_thsv_host_model.clr_events(v);
        wt("irq", 0, 1'b1);
        // Clear lands on the edge the event sets
        temp_warn_cmp = 1'b1;
        cyc(1);
        u_thsv_host_model.wr(EVENTS_ADDR, 8'h04);
        cyc(4);
        rdchk("events", EVENTS_ADDR, 8'h04);
        temp_warn_cmp = 1'b0;
        u_thsv_host_model.clr_events(v);
        // Critical shutdown, no automatic restart, then both restart paths
        u_thsv_host_model.wr(CONV_FIRST_ADDR, 8'h01);
        control_input_pin = 2'h2;
        thermal_critical_status_cmp = 1'b1;
        wt("conv1", 1, 1'b0);
        chk("conv2", 8'h00, {7'h00, second_converter_on});
        u_thsv_host_model.wr(CONV_FIRST_ADDR, 8'h01);
        rdchk("conv1", CONV_FIRST_ADDR, 8'h00);
        rdchk("events", EVENTS_ADDR, 8'h08);
        chk("irq", 8'h00, {7'h00, interrupt_out_low});
        thermal_critical_status_cmp = 1'b0;
        cyc(10);
        chk("conv2", 8'h00, {7'h00, second_converter_on});
        u_thsv_host_model.wr(CONV_FIRST_ADDR, 8'h01);
        wt("conv1", 1, 1'b1);
        control_input_pin = 2'h0;
        cyc(5);
        control_input_pin = 2'h2;
        cyc(6);
        chk("conv2", 8'h01, {7'h00, second_converter_on});
        u_thsv_host_model.clr_events(v);
        wt("irq", 0, 1'b1);
        // Overheat reset clears the registers
        u_thsv_host_model.wr(MASKS_ADDR, 8'h0C);
        temp_por_cmp = 1'b1;
        wt("por", 2, 1'b1);
        // Stay hot long enough for the held reset to show on the converter and reset outputs
        cyc(3);
        chk("por", 8'h01, {7'h00, core_por});
        chk("conv2", 8'h00, {7'h00, second_converter_on});
        temp_por_cmp = 1'b0;
        wt("por", 2, 1'b0);
        rdchk("masks", MASKS_ADDR, MASKS_RST);
        test_done();
    end
endmodule // tb
bind thsv_supervisor thsv_supervisor_monitor u_thsv_supervisor_monitor (.clk, .rstn,
    .temp_warn_cmp, .thermal_critical_status_cmp, .temp_por_cmp, .control_input_pin, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .interrupt_out_low, .first_converter_on, .second_converter_on,
    .core_por);
`default_nettype wire
